// ==== rtl/prde_pkg.sv ====
// shared constants and types for the panel data exchange block
package prde_pkg;
  localparam int KEY_COUNT      = 256;             // key flag bits K1..K256
  localparam int KEY_ENTER_POS  = 1;               // K1
  localparam int KEY_HELP_POS   = 15;              // K15
  localparam int KEY_CLEAR_POS  = 16;              // K16
  localparam int LED_COUNT      = 32;              // L1..L32
  localparam int CLK_HZ         = 100_000_000;
  localparam int HEARTBEAT_MS   = 1000;            // heartbeat half period in ms
  localparam int HEARTBEAT_CYC  = (CLK_HZ / 1000) * HEARTBEAT_MS;
  localparam int WATCH_MS       = 1000;            // host watchdog window in ms
  localparam int WATCH_CYC      = (CLK_HZ / 1000) * WATCH_MS;
  localparam int CNT_W          = 28;
  localparam int BIT_LINK       = 0;
  localparam int BIT_ENTRY      = 1;
  localparam int BIT_PRINTING   = 2;
  localparam int BIT_PRN_READY  = 3;
  localparam int BIT_CLK_UPD    = 4;
  localparam int BIT_PROTECT    = 5;
  localparam int BIT_BATT_LOW   = 6;
  localparam int BIT_ALARM      = 7;
  localparam int BIT_UNACK      = 8;
  localparam int BIT_BACKUP     = 12;
  localparam int BIT_RCP_UP     = 13;
  localparam int BIT_RCP_DOWN   = 14;
  localparam int BIT_RCP_BAD    = 15;
  localparam logic [15:0] COND_RESET  = 16'h0000;
  localparam logic [15:0] PAGE_RESET  = 16'h0000;
  localparam logic [47:0] CLOCK_RESET = 48'h0;
  // host register offsets
  localparam logic [3:0] REG_COND      = 4'h0;
  localparam logic [3:0] REG_PAGE      = 4'h1;
  localparam logic [3:0] REG_LINKOK    = 4'h2;
  localparam logic [3:0] REG_CLOCK_LO  = 4'h3;
  localparam logic [3:0] REG_CLOCK_HI  = 4'h4;
  localparam logic [3:0] REG_PAGE_REQ  = 4'h5;
  localparam logic [3:0] REG_CTRL      = 4'h6;
  localparam logic [3:0] REG_LED_LO    = 4'h7;
  localparam logic [3:0] REG_LED_HI    = 4'h8;
  localparam logic [3:0] REG_KEY_BASE  = 4'h9;  // key word n at 9+n, n=0..3 (32 bits each, only K1..K128 readable)
  typedef enum logic [1:0] {PRDE_CLK_IDLE, PRDE_CLK_MARK, PRDE_CLK_WRITE, PRDE_CLK_DONE} prde_clk_t;
endpackage : prde_pkg

// ==== rtl/prde_if.sv ====
// shared exchange area carrier between panel and controller
`timescale 1ns/10ps
`default_nettype none
interface prde_if;
  import prde_pkg::*;
  logic [KEY_COUNT-1:0] keyFlags;       // bit n-1 is key Kn
  logic [47:0]          clockRecord;
  logic [15:0]          conditionWord;
  logic [15:0]          displayedPageValue;
  logic [15:0]          pageRequest;
  logic                 pageRequestStb;
  logic [15:0]          controlWord;
  logic [LED_COUNT-1:0] ledBits;
  modport panel (output keyFlags, clockRecord, conditionWord, displayedPageValue,
                 input pageRequest, pageRequestStb, controlWord, ledBits);
  modport ctrl  (input keyFlags, clockRecord, conditionWord, displayedPageValue,
                 output pageRequest, pageRequestStb, controlWord, ledBits);
endinterface : prde_if
`default_nettype wire

// ==== rtl/prde_panel.sv ====
// panel end: publishes keys, clock record, condition word and page
`timescale 1ns/10ps
`default_nettype none
module prde_panel #(
  parameter int BEAT_CYC = prde_pkg::HEARTBEAT_CYC  // heartbeat half period in cycles
) (
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  prde_if.panel                              link,
  input  wire logic [prde_pkg::KEY_COUNT-1:0] keysHeld,
  input  wire logic                          keyEnter,
  input  wire logic                          keyClear,
  input  wire logic                          keyHelp,
  input  wire logic                          linkUp,
  input  wire logic                          entryMode,
  input  wire logic                          pageMode,
  input  wire logic                          printing,
  input  wire logic                          printerCts,
  input  wire logic                          clockWrite,
  input  wire logic                          clockSecondsOnly,
  input  wire logic [47:0]                   clockNew,
  input  wire logic                          protectHit,
  input  wire logic                          protectClr,
  input  wire logic                          batteryWeak,
  input  wire logic [15:0]                   alarmActive,
  input  wire logic [15:0]                   alarmUnacked,
  input  wire logic                          backupBusy,
  input  wire logic                          recipeUpload,
  input  wire logic                          recipeDownload,
  input  wire logic                          recipeInvalid,
  input  wire logic [15:0]                   pageNumber,
  input  wire logic                          pageBcd,
  output logic [15:0]                        pageRequested,
  output logic                               pageRequestNew,
  output logic [15:0]                        controlSeen,
  output logic [prde_pkg::LED_COUNT-1:0]     ledsOut
);
  import prde_pkg::*;

  logic [KEY_COUNT-1:0] keyMeta_q, keySync_q, keyLine;
  logic [2:0]           dedMeta_q, dedSync_q;
  logic                 ctsMeta_q, ctsSync_q, batMeta_q, batSync_q;
  logic [CNT_W-1:0]     beatCnt_q;
  logic                 beat_q, protect_q;
  prde_clk_t            clkState_q;
  logic [47:0]          clock_q, clockStage_q;
  logic [15:0]          page_q, cond_q, condD, pageD, pageBcdVal;
  logic                 clkMark;

  // pin synchronisers for keys, printer line and battery sense
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      keyMeta_q <= '0; keySync_q <= '0; dedMeta_q <= '0; dedSync_q <= '0;
      ctsMeta_q <= 1'b0; ctsSync_q <= 1'b0; batMeta_q <= 1'b0; batSync_q <= 1'b0;
    end else begin
      keyMeta_q <= keysHeld;
      keySync_q <= keyMeta_q;
      dedMeta_q <= {keyClear, keyHelp, keyEnter};
      dedSync_q <= dedMeta_q;
      ctsMeta_q <= printerCts;
      ctsSync_q <= ctsMeta_q;
      batMeta_q <= batteryWeak;
      batSync_q <= batMeta_q;
    end
  end

  // key flags: dedicated keys merge into their fixed positions
  genvar gi;
  generate
    for (gi = 0; gi < KEY_COUNT; gi++) begin : g_key
      if (gi == KEY_ENTER_POS-1) begin : g_ent
        assign keyLine[gi] = keySync_q[gi] | dedSync_q[0];
      end else if (gi == KEY_HELP_POS-1) begin : g_hlp
        assign keyLine[gi] = keySync_q[gi] | dedSync_q[1];
      end else if (gi == KEY_CLEAR_POS-1) begin : g_clr
        assign keyLine[gi] = keySync_q[gi] | dedSync_q[2];
      end else begin : g_pl
        assign keyLine[gi] = keySync_q[gi];
      end
    end
  endgenerate

  // heartbeat counter, runs only while the link works
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beatCnt_q <= '0;
      beat_q    <= 1'b0;
    end else if (linkUp) begin
      if (beatCnt_q == CNT_W'(BEAT_CYC - 1)) begin
        beatCnt_q <= '0;
        beat_q    <= ~beat_q;
      end else begin
        beatCnt_q <= beatCnt_q + 1'b1;
      end
    end
  end

  // clock record update: mark, write, unmark
  // a full record is staged on acceptance and written only once the flag already shows,
  // so a reader never sees a fresh full record beside a clear flag; seconds-only writes go straight in, unflagged
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkState_q   <= PRDE_CLK_IDLE;
      clock_q      <= CLOCK_RESET;
      clockStage_q <= CLOCK_RESET;
    end else begin
      case (clkState_q)
        PRDE_CLK_IDLE: begin
          if (clockWrite && clockSecondsOnly) begin
            clock_q <= clockNew;
          end else if (clockWrite) begin
            clockStage_q <= clockNew;
            clkState_q   <= PRDE_CLK_MARK;
          end
        end
        PRDE_CLK_MARK:  clkState_q <= PRDE_CLK_WRITE;
        PRDE_CLK_WRITE: begin
          clock_q    <= clockStage_q;
          clkState_q <= PRDE_CLK_DONE;
        end
        PRDE_CLK_DONE:  clkState_q <= PRDE_CLK_IDLE;
        default:        clkState_q <= PRDE_CLK_IDLE;
      endcase
    end
  end
  assign clkMark = (clkState_q == PRDE_CLK_MARK) || (clkState_q == PRDE_CLK_WRITE);

  // protected access flag: sticky, set wins over clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      protect_q <= 1'b0;
    end else begin
      protect_q <= protectHit | (protect_q & ~protectClr);
    end
  end

  // condition word assembly; bits 9-11 stay zero
  always_comb begin
    condD                = COND_RESET;
    condD[BIT_LINK]      = beat_q;
    condD[BIT_ENTRY]     = entryMode;
    condD[BIT_PRINTING]  = printing;
    condD[BIT_PRN_READY] = ctsSync_q;
    condD[BIT_CLK_UPD]   = clkMark;
    condD[BIT_PROTECT]   = protect_q;
    condD[BIT_BATT_LOW]  = batSync_q;
    condD[BIT_ALARM]     = |alarmActive;
    condD[BIT_UNACK]     = |(alarmActive & alarmUnacked);
    condD[BIT_BACKUP]    = backupBusy;
    condD[BIT_RCP_UP]    = recipeUpload;
    condD[BIT_RCP_DOWN]  = recipeDownload;
    condD[BIT_RCP_BAD]   = recipeInvalid;
  end

  // page value in binary or packed decimal (values above 9999 wrap)
  assign pageBcdVal = {4'((pageNumber / 16'd1000) % 16'd10), 4'((pageNumber / 16'd100) % 16'd10),
                       4'((pageNumber / 16'd10) % 16'd10), 4'(pageNumber % 16'd10)};
  assign pageD = (pageMode || entryMode) ? (pageBcd ? pageBcdVal : pageNumber) : PAGE_RESET;

  // registered status region
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cond_q <= COND_RESET;
      page_q <= PAGE_RESET;
    end else begin
      cond_q <= condD;
      page_q <= pageD;
    end
  end

  // publish into the exchange area
  assign link.keyFlags           = keyLine;
  assign link.clockRecord        = clock_q;
  assign link.conditionWord      = cond_q;
  assign link.displayedPageValue = page_q;

  // controller orders passed to panel logic
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pageRequested  <= '0;
      pageRequestNew <= 1'b0;
      controlSeen    <= '0;
      ledsOut        <= '0;
    end else begin
      pageRequestNew <= link.pageRequestStb;
      if (link.pageRequestStb) begin
        pageRequested <= link.pageRequest;
      end
      controlSeen <= link.controlWord;
      ledsOut     <= link.ledBits;
    end
  end
endmodule : prde_panel
`default_nettype wire

// ==== rtl/prde_ctrl.sv ====
// controller end: register port onto the exchange area with heartbeat watchdog
`timescale 1ns/10ps
`default_nettype none
module prde_ctrl #(
  parameter int WATCH_LIM = prde_pkg::WATCH_CYC  // heartbeat silence allowed, in cycles
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  prde_if.ctrl             link,
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic             linkOk
);
  import prde_pkg::*;

  logic [CNT_W-1:0] watchCnt_q;
  logic             beatLast_q, seen_q, linkOk_q;
  logic [47:0]      clockHeld_q;
  logic             clockStale_q;
  logic [15:0]      pageReq_q, ctrl_q;
  logic             pageStb_q;
  logic [31:0]      led_q, rdMux;
  logic [1:0]       keyIdx;
  logic             beatEdge;

  // heartbeat watchdog: fault when no change within the window
  assign beatEdge = link.conditionWord[BIT_LINK] ^ beatLast_q;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchCnt_q <= '0;
      beatLast_q <= 1'b0;
      seen_q     <= 1'b0;
      linkOk_q   <= 1'b0;
    end else begin
      beatLast_q <= link.conditionWord[BIT_LINK];
      if (beatEdge) begin
        watchCnt_q <= '0;
        seen_q     <= 1'b1;
        linkOk_q   <= seen_q;
      end else if (watchCnt_q == CNT_W'(WATCH_LIM)) begin
        linkOk_q <= 1'b0;
      end else begin
        watchCnt_q <= watchCnt_q + 1'b1;
      end
    end
  end
  assign linkOk = linkOk_q;

  // clock record taken only while no update is marked
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clockHeld_q  <= CLOCK_RESET;
      clockStale_q <= 1'b1;
    end else if (!link.conditionWord[BIT_CLK_UPD]) begin
      clockHeld_q  <= link.clockRecord;
      clockStale_q <= 1'b0;
    end else begin
      clockStale_q <= 1'b1;
    end
  end

  // controller update area writes
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pageReq_q <= '0;
      pageStb_q <= 1'b0;
      ctrl_q    <= '0;
      led_q     <= '0;
    end else begin
      pageStb_q <= regWr && (regAddr == REG_PAGE_REQ);
      if (regWr && regAddr == REG_PAGE_REQ) pageReq_q <= regWdata[15:0];
      if (regWr && regAddr == REG_CTRL) ctrl_q <= regWdata[15:0];
      if (regWr && regAddr == REG_LED_LO) led_q[15:0] <= regWdata[15:0];
      if (regWr && regAddr == REG_LED_HI) led_q[31:16] <= regWdata[15:0];
    end
  end
  assign link.pageRequest    = pageReq_q;
  assign link.pageRequestStb = pageStb_q;
  assign link.controlWord    = ctrl_q;
  assign link.ledBits        = led_q;

  // read decode; unmapped reads return zero
  assign keyIdx = 2'(regAddr - REG_KEY_BASE);
  always_comb begin
    rdMux = 32'h0;
    case (regAddr)
      REG_COND:     rdMux = {16'h0, link.conditionWord};
      REG_PAGE:     rdMux = {16'h0, link.displayedPageValue};
      REG_LINKOK:   rdMux = {30'h0, clockStale_q, linkOk_q};
      REG_CLOCK_LO: rdMux = clockHeld_q[31:0];
      REG_CLOCK_HI: rdMux = {16'h0, clockHeld_q[47:32]};
      REG_PAGE_REQ: rdMux = {16'h0, pageReq_q};
      REG_CTRL:     rdMux = {16'h0, ctrl_q};
      REG_LED_LO:   rdMux = {16'h0, led_q[15:0]};
      REG_LED_HI:   rdMux = {16'h0, led_q[31:16]};
      4'h9, 4'ha, 4'hb, 4'hc: rdMux = link.keyFlags[32*keyIdx +: 32];
      default:      rdMux = 32'h0;
    endcase
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdata <= 32'h0;
    end else begin
      regRdata <= regRd ? rdMux : 32'h0;
    end
  end
endmodule : prde_ctrl
`default_nettype wire

// ==== test/prde_link_assertions.sv ====
// concurrent checks on the condition word and clock record of the exchange area
`timescale 1ns/10ps
`default_nettype none
module prde_link_assertions #(
  parameter int BEAT_CYC = prde_pkg::HEARTBEAT_CYC  // heartbeat half period in cycles
) (
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  input wire logic [47:0] clockRecord,
  input wire logic [15:0] conditionWord
);
  import prde_pkg::*;
  localparam int BEAT_MIN = BEAT_CYC / 2;
  logic [CNT_W-1:0] beatAge_q;
  logic [CNT_W-1:0] beatAge_d;
  logic             lastBeat_q;
  logic             beatMoved;
  // age of the heartbeat bit in cycles, saturating so it never wraps
  assign beatMoved = conditionWord[BIT_LINK] != lastBeat_q;
  assign beatAge_d = beatMoved ? '0 : ((&beatAge_q) ? beatAge_q : beatAge_q + 1'b1);
  // heartbeat history
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      beatAge_q  <= '0;
      lastBeat_q <= 1'b0;
    end else begin
      beatAge_q  <= beatAge_d;
      lastBeat_q <= conditionWord[BIT_LINK];
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  property p_spare_zero;
    conditionWord[11:9] == 3'h0;
  endproperty
  a_spare_zero: assert property (p_spare_zero)
    else $error("spare condition bits not zero");
  property p_upd_pulse;
    $rose(conditionWord[BIT_CLK_UPD]) |=> conditionWord[BIT_CLK_UPD] ##1 !conditionWord[BIT_CLK_UPD];
  endproperty
  a_upd_pulse: assert property (p_upd_pulse)
    else $error("clock update flag not held for two cycles");
  property p_upd_short;
    conditionWord[BIT_CLK_UPD] ##1 conditionWord[BIT_CLK_UPD] |=> !conditionWord[BIT_CLK_UPD];
  endproperty
  a_upd_short: assert property (p_upd_short)
    else $error("clock update flag stuck high");
  property p_rec_frozen;
    $rose(conditionWord[BIT_CLK_UPD]) || $fell(conditionWord[BIT_CLK_UPD])
      |-> $stable(clockRecord);
  endproperty
  a_rec_frozen: assert property (p_rec_frozen)
    else $error("clock record moved while update flag was changing");
  property p_alarm_nest;
    conditionWord[BIT_UNACK] |-> conditionWord[BIT_ALARM];
  endproperty
  a_alarm_nest: assert property (p_alarm_nest)
    else $error("unacknowledged alarm flag without alarm flag");
  property p_beat_slow;
    beatMoved |-> beatAge_q >= BEAT_MIN;
  endproperty
  a_beat_slow: assert property (p_beat_slow)
    else $error("heartbeat bit toggled too early");
endmodule : prde_link_assertions
`default_nettype wire

// ==== test/tb.sv ====
// self-checking bench joining the panel end and the controller end
`timescale 1ns/10ps
`default_nettype none
module tb;
  import prde_pkg::*;
  localparam int TB_BEAT  = 100;  // shortened heartbeat half period for the run
  localparam int TB_WATCH = 150;  // shortened watchdog window, longer than the heartbeat
  logic                 sys_clk, sys_rst, keyEnter, keyClear, keyHelp, linkUp, entryMode;
  logic                 pageMode, printing, printerCts, clockWrite, clockSecondsOnly, pageBcd;
  logic                 protectHit, protectClr, batteryWeak, backupBusy, recipeUpload;
  logic                 recipeDownload, recipeInvalid, pageRequestNew, regWr, regRd, linkOk;
  logic [KEY_COUNT-1:0] keysHeld;
  logic [47:0]          clockNew;
  logic [15:0]          alarmActive, alarmUnacked, pageNumber, pageRequested, controlSeen;
  logic [LED_COUNT-1:0] ledsOut;
  logic [3:0]           regAddr;
  logic [31:0]          regWdata, regRdata, rdv;
  int                   errTotal, nCompared;
  prde_if lnk ();
  prde_panel #(.BEAT_CYC(TB_BEAT))
    u_prde_panel (.sys_clk, .sys_rst, .link(lnk), .keysHeld, .keyEnter, .keyClear,
    .keyHelp, .linkUp, .entryMode, .pageMode, .printing, .printerCts, .clockWrite,
    .clockSecondsOnly, .clockNew, .protectHit, .protectClr, .batteryWeak, .alarmActive,
    .alarmUnacked, .backupBusy, .recipeUpload, .recipeDownload, .recipeInvalid, .pageNumber,
    .pageBcd, .pageRequested, .pageRequestNew, .controlSeen, .ledsOut);
  prde_ctrl #(.WATCH_LIM(TB_WATCH))
    u_prde_ctrl (.sys_clk, .sys_rst, .link(lnk), .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .linkOk);
  prde_link_assertions #(.BEAT_CYC(TB_BEAT))
    u_prde_link_assertions (.sys_clk, .sys_rst,
    .clockRecord(lnk.clockRecord), .conditionWord(lnk.conditionWord));
  // free-running clock
  always #5 sys_clk = ~sys_clk;
  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    nCompared++;
    if (seen !== want) begin
      errTotal++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  // one-cycle register write
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask : wr
  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 rdv = regRdata;
  endtask : rd
  task automatic test_keys();
    cyc(1);
    keysHeld <= 256'h20;
    keyEnter <= 1'b1;
    keyHelp  <= 1'b1;
    cyc(5);
    #1 check(lnk.keyFlags[15:0], 16'h4021);
    rd(REG_KEY_BASE);
    check(rdv, 32'h4021);
    cyc(1);
    {keysHeld, keyEnter, keyHelp, keyClear} <= {256'h0, 3'b001};
    cyc(5);
    #1 check(lnk.keyFlags[47:0], 48'h8000);
    cyc(1);
    keyClear <= 1'b0;
    cyc(5);
    #1 check(|lnk.keyFlags, 1'b0);
    $display("keys test done");
  endtask : test_keys
  task automatic test_status();
    cyc(1);
    {entryMode, printing, printerCts, batteryWeak, backupBusy, recipeUpload, recipeInvalid} <= 7'h7f;
    alarmActive  <= 16'h0004;
    alarmUnacked <= 16'h0004;
    wr(REG_COND, 32'hffff);
    cyc(5);
    rd(REG_COND);
    check(rdv, 32'hb1ce);
    cyc(1);
    {entryMode, printing, printerCts, batteryWeak, backupBusy, recipeUpload, recipeInvalid} <= 7'h0;
    recipeDownload <= 1'b1;
    alarmUnacked   <= 16'h0008;
    protectHit     <= 1'b1;
    cyc(1);
    protectHit <= 1'b0;
    cyc(5);
    rd(REG_COND);
    check(rdv, 32'h40a0);
    cyc(1);
    {alarmActive, recipeDownload, protectClr} <= {16'h0, 2'b01};
    cyc(1);
    protectClr <= 1'b0;
    cyc(5);
    rd(REG_COND);
    check(rdv, 32'h0);
    check(linkOk, 1'b0);
    $display("status test done");
  endtask : test_status
  task automatic clk_upd(input logic secOnly, input logic [47:0] rec, input int marks);
    int n;
    n = 0;
    cyc(1);
    {clockNew, clockSecondsOnly, clockWrite} <= {rec, secOnly, 1'b1};
    cyc(1);
    clockWrite <= 1'b0;
    repeat (6) begin
      @(posedge sys_clk);
      #1 if (lnk.conditionWord[BIT_CLK_UPD] === 1'b1) n++;
    end
    check(n, marks);
    check(lnk.clockRecord, rec);
    rd(REG_CLOCK_LO);
    check(rdv, rec[31:0]);
    rd(REG_CLOCK_HI);
    check(rdv, {16'h0, rec[47:32]});
    $display("clock update test done");
  endtask : clk_upd
  task automatic pg(input logic pm, input logic em, input logic bcd, input logic [15:0] want);
    cyc(1);
    {pageMode, entryMode, pageBcd, pageNumber} <= {pm, em, bcd, 16'd1234};
    cyc(4);
    rd(REG_PAGE);
    check(rdv, {16'h0, want});
    check(lnk.displayedPageValue, want);
    $display("page test done");
  endtask : pg
  task automatic test_ctrl();
    int n;
    n = 0;
    wr(REG_PAGE_REQ, 32'h0007);
    repeat (4) begin
      @(posedge sys_clk);
      #1 if (pageRequestNew === 1'b1) n++;
    end
    check(n, 1);
    check(pageRequested, 16'h0007);
    wr(REG_CTRL, 32'h00a5);
    wr(REG_LED_LO, 32'hbeef);
    wr(REG_LED_HI, 32'h1234);
    cyc(3);
    #1 check(controlSeen, 16'h00a5);
    check(ledsOut, 32'h1234beef);
    rd(4'hf);
    check(rdv, 32'h0);
    $display("controller update test done");
  endtask : test_ctrl
  // heartbeat: two toggles bring the link up, silence takes it down again
  task automatic test_beat();
    cyc(1);
    linkUp <= 1'b1;
    cyc(TB_BEAT);
    #1 check(lnk.conditionWord[BIT_LINK], 1'b0);
    cyc(1);
    #1 check(lnk.conditionWord[BIT_LINK], 1'b1);
    cyc(TB_BEAT);
    #1 check(linkOk, 1'b0);
    cyc(1);
    #1 check(linkOk, 1'b1);
    rd(REG_LINKOK);
    check(rdv, 32'h1);
    cyc(1);
    linkUp <= 1'b0;
    cyc(TB_WATCH - 3);
    #1 check(linkOk, 1'b1);
    cyc(1);
    #1 check(linkOk, 1'b0);
    $display("heartbeat test done");
  endtask : test_beat
  task automatic conclude();
    $display("compared %0d, mismatches %0d", nCompared, errTotal);
    if (errTotal == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // main sequence
  initial begin
    {keysHeld, keyEnter, keyClear, keyHelp, linkUp, entryMode, pageMode, printing} = 0;
    {printerCts, clockWrite, clockSecondsOnly, clockNew, protectHit, protectClr} = 0;
    {batteryWeak, alarmActive, alarmUnacked, backupBusy, recipeUpload, recipeDownload} = 0;
    {recipeInvalid, pageNumber, pageBcd, regAddr, regWdata, regWr, regRd} = 0;
    {errTotal, nCompared} = 0;
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    cyc(8);
    sys_rst <= 1'b0;
    test_keys();
    test_status();
    clk_upd(1'b0, 48'h0123456789ab, 2);
    clk_upd(1'b1, 48'h0123456789ac, 0);
    pg(1'b1, 1'b0, 1'b0, 16'h04d2);
    pg(1'b1, 1'b0, 1'b1, 16'h1234);
    pg(1'b0, 1'b1, 1'b0, 16'h04d2);
    pg(1'b0, 1'b0, 1'b1, 16'h0000);
    test_ctrl();
    test_beat();
    conclude();
  end
  // watchdog against a hung handshake
  initial begin
    cyc(20000);
    errTotal++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    conclude();
  end
endmodule : tb
`default_nettype wire
